// [design/qhp_consts.svh]
/*
  qhp_consts.svh - offsets, field positions, reset values and sizes of the
  queue host data port register bank.
  Assumes: included by bare name from the design module only.
*/
`ifndef QHP_CONSTS_SVH
`define QHP_CONSTS_SVH

// ---------------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------------
`define QHP_OFS_INT_ENABLE   8'h00
`define QHP_OFS_INT_STATUS   8'h02
`define QHP_OFS_RX_POINTER   8'h06
`define QHP_OFS_DATA_LOW     8'h08
`define QHP_OFS_DATA_HIGH    8'h0A
`define QHP_OFS_RX_COMMAND   8'h0C

// ---------------------------------------------------------------------
// field positions and masks
// ---------------------------------------------------------------------
`define QHP_PTR_AUTO_BIT     14
`define QHP_PTR_MSB          10
`define QHP_PTR_RW_MASK      16'h47FF
`define QHP_INT_RW_MASK      16'hFF80
`define QHP_CMD_RELEASE_BIT  0

// ---------------------------------------------------------------------
// reset values and sizes
// ---------------------------------------------------------------------
`define QHP_RST_WORD         16'h0000
`define QHP_RST_PTR          11'h000
`define QHP_QUEUE_DEPTH      2048
`define QHP_WIN_ADDR_MASK    8'hFC

`endif

// [design/qhp_pkg.sv]
/*
  qhp_pkg - types shared by the queue host data port.
  Assumes: nothing beyond a SystemVerilog compiler.
*/
package qhp_pkg;

  // access width of one bus transfer, one-hot
  typedef enum logic [2:0] {
    QHP_BYTE  = 3'b001,
    QHP_WORD  = 3'b010,
    QHP_DWORD = 3'b100
  } qhp_size_e;

  // release handshake with the queue manager, one-hot
  typedef enum logic [1:0] {
    QHP_REL_IDLE = 2'b01,
    QHP_REL_WAIT = 2'b10
  } qhp_rel_e;

  // interrupt sources in the layout of the enable and status registers
  typedef struct packed {
    logic       link_change;
    logic       transmit_done;
    logic       receive_frame;
    logic       transmit_underrun;
    logic       receive_overrun;
    logic       early_receive;
    logic       transmit_stopped;
    logic       receive_stopped;
    logic       receive_error_frame;
    logic [6:0] rsvd;
  } qhp_irq_s;

endpackage : qhp_pkg

// [design/qhp_top.sv]
/*
  qhp_top - host side access to the receive and transmit queues: receive
  pointer with auto step, data window, interrupt enable/status and the
  frame release command.
  Assumes: host bus and queue manager logic run on REF_CLK_I; the host
  never raises both strobes in one cycle.
*/
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "qhp_consts.svh"

// Notes on behaviour
// RULE1 - with auto step set, each data window read advances receive pointer
// RULE2 - step equals access width: one, two or four bytes
// RULE3 - auto step clear: data accesses leave pointer alone; host sets it
// RULE4 - pointer is 11 bits at 10:0, resets zero, reloads on release
// RULE5 - low and high window words are the bytes at the pointer
// RULE6 - window reads come from receive queue, writes go to transmit queue
// RULE7 - window works at any byte alignment of the pointer
// RULE8 - byte, word and dword window accesses mix freely
// RULE9 - window words sit at two word addresses, or one dword
// RULE10 - enable bits 15 link change, 14 transmit done, 13 receive frame
// RULE11 - enable bits 12 underrun, 11 overrun, 10 early receive
// RULE12 - enable bits 9 tx stopped, 8 rx stopped, 7 error frame
// RULE13 - enables reset to zero; a clear enable blocks its source
// RULE14 - writing one to release bit frees frame; bit self-clears when done
// RULE15 - interrupt output high while any status bit and its enable set
// RULE16 - status bits stay set on read, clear on writing one
// RULE17 - reserved pointer and enable bits read zero, ignore writes
// RULE18 - pointer auto step wraps within eleven bits
module qhp_top (
  // clock and reset
  input  wire logic                REF_CLK_I,
  input  wire logic                RSTN_I,
  // host register port
  input  wire logic [7:0]          ADDR_I,
  input  wire logic [31:0]         WR_DATA_I,
  input  wire qhp_pkg::qhp_size_e  SIZE_I,
  input  wire logic                WR_I,
  input  wire logic                RD_I,
  output logic      [31:0]         RD_DATA_O,
  // queue manager side
  input  wire logic                RXQ_WR_I,
  input  wire logic [10:0]         RXQ_WR_ADDR_I,
  input  wire logic [7:0]          RXQ_WR_DATA_I,
  input  wire logic [10:0]         TX_PTR_I,
  input  wire logic [10:0]         TXQ_RD_ADDR_I,
  output logic      [7:0]          TXQ_RD_DATA_O,
  output logic                     RELEASE_REQ_O,
  input  wire logic                RELEASE_DONE_I,
  input  wire logic [10:0]         RELEASE_PTR_I,
  // interrupt sources and output
  input  wire qhp_pkg::qhp_irq_s   IRQ_EVT_I,
  output logic                     IRQ_O
);

  // -------------------------------------------------------------------
  // storage and state
  // -------------------------------------------------------------------
  logic [7:0]        rx_queue [`QHP_QUEUE_DEPTH];
  logic [7:0]        tx_queue [`QHP_QUEUE_DEPTH];
  logic [10:0]       rx_pointer_index;
  logic              rx_pointer_auto_step;
  logic [15:0]       interrupt_enable;
  logic [15:0]       int_status;
  qhp_pkg::qhp_rel_e rel_state;
  logic [31:0]       next_rd_data;
  logic [2:0]        nbytes;
  logic [10:0]       step;
  logic [1:0]        win_off;
  logic              win_sel;
  logic              win_rd;
  logic              win_wr;
  logic              wr_ptr;
  logic              wr_ien;
  logic              wr_ist;
  logic              wr_cmd;
  logic [15:0]       evt;
  logic              rel_pending;

  // -------------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------------
  // low and high words share one dword window at 0x08..0x0B
  assign win_sel = (ADDR_I & `QHP_WIN_ADDR_MASK) == `QHP_OFS_DATA_LOW; // RULE9
  assign win_off = ADDR_I[1:0];
  assign win_rd  = RD_I && win_sel;
  assign win_wr  = WR_I && win_sel;
  assign wr_ptr  = WR_I && (ADDR_I == `QHP_OFS_RX_POINTER);
  assign wr_ien  = WR_I && (ADDR_I == `QHP_OFS_INT_ENABLE);
  assign wr_ist  = WR_I && (ADDR_I == `QHP_OFS_INT_STATUS);
  assign wr_cmd  = WR_I && (ADDR_I == `QHP_OFS_RX_COMMAND);
  assign evt     = IRQ_EVT_I;
  assign rel_pending = (rel_state == qhp_pkg::QHP_REL_WAIT);

  // bytes moved per access; an unknown size code moves one byte
  always_comb begin
    case (SIZE_I)
      qhp_pkg::QHP_WORD:  nbytes = 3'd2;
      qhp_pkg::QHP_DWORD: nbytes = 3'd4;
      default:            nbytes = 3'd1;
    endcase
  end
  assign step = {8'h00, nbytes}; // RULE2

  // -------------------------------------------------------------------
  // receive pointer
  // -------------------------------------------------------------------
  // reload beats a host write, which beats the auto step; the sum is
  // eleven bits wide so it wraps and never reaches the control bit
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rx_pointer_index     <= `QHP_RST_PTR; // RULE4
      rx_pointer_auto_step <= 1'b0;
    end else if (rel_pending && RELEASE_DONE_I) begin
      rx_pointer_index <= RELEASE_PTR_I; // RULE4
    end else if (wr_ptr) begin
      rx_pointer_index     <= WR_DATA_I[`QHP_PTR_MSB:0]; // RULE3
      rx_pointer_auto_step <= WR_DATA_I[`QHP_PTR_AUTO_BIT];
    end else if (win_rd && rx_pointer_auto_step) begin
      rx_pointer_index <= rx_pointer_index + step; // RULE1 RULE18
    end
  end

  // -------------------------------------------------------------------
  // queue memories
  // -------------------------------------------------------------------
  // receive queue is filled by the queue manager, one byte a cycle
  always_ff @(posedge REF_CLK_I) begin
    if (RXQ_WR_I) begin
      rx_queue[RXQ_WR_ADDR_I] <= RXQ_WR_DATA_I;
    end
  end

  // host writes land in the transmit queue at the transmit pointer plus
  // the lane offset, so any alignment and width works
  always_ff @(posedge REF_CLK_I) begin
    if (win_wr) begin
      for (int k = 0; k < 4; k++) begin
        if (3'(k) < nbytes) begin
          tx_queue[11'(TX_PTR_I + {9'h000, win_off} + 11'(k))] <=
            WR_DATA_I[8*k +: 8]; // RULE6 RULE7 RULE8
        end
      end
    end
  end

  // transmit queue read port for the transmit side
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TXQ_RD_DATA_O <= 8'h00;
    end else begin
      TXQ_RD_DATA_O <= tx_queue[TXQ_RD_ADDR_I];
    end
  end

  // -------------------------------------------------------------------
  // interrupt enable, status and output
  // -------------------------------------------------------------------
  // reserved low bits are masked off on every write
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      interrupt_enable <= `QHP_RST_WORD; // RULE13
    end else if (wr_ien) begin
      interrupt_enable <= WR_DATA_I[15:0] & `QHP_INT_RW_MASK; // RULE10 RULE11 RULE12 RULE17
    end
  end

  // sticky status: an event in the clearing cycle wins over the clear
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      int_status <= `QHP_RST_WORD;
    end else begin
      int_status <= ((int_status & ~(wr_ist ? WR_DATA_I[15:0] : 16'h0000))
                     | evt) & `QHP_INT_RW_MASK; // RULE16
    end
  end

  assign IRQ_O = |(int_status & interrupt_enable); // RULE13 RULE15

  // -------------------------------------------------------------------
  // frame release handshake
  // -------------------------------------------------------------------
  // the command bit stays high until the queue manager reports the frame
  // freed; a second write meanwhile is ignored
  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      rel_state <= qhp_pkg::QHP_REL_IDLE;
    end else begin
      case (rel_state)
        qhp_pkg::QHP_REL_IDLE: begin
          if (wr_cmd && WR_DATA_I[`QHP_CMD_RELEASE_BIT]) begin
            rel_state <= qhp_pkg::QHP_REL_WAIT; // RULE14
          end
        end
        qhp_pkg::QHP_REL_WAIT: begin
          if (RELEASE_DONE_I) begin
            rel_state <= qhp_pkg::QHP_REL_IDLE; // RULE14
          end
        end
        default: rel_state <= qhp_pkg::QHP_REL_IDLE;
      endcase
    end
  end
  assign RELEASE_REQ_O = rel_pending;

  // -------------------------------------------------------------------
  // read data
  // -------------------------------------------------------------------
  // window reads gather bytes from pointer plus lane offset; unused lanes
  // and unmapped addresses read zero
  always_comb begin
    next_rd_data = 32'h0000_0000;
    if (RD_I) begin
      if (win_sel) begin
        for (int k = 0; k < 4; k++) begin
          if (3'(k) < nbytes) begin
            next_rd_data[8*k +: 8] = rx_queue[11'(rx_pointer_index
              + {9'h000, win_off} + 11'(k))]; // RULE5 RULE6 RULE7
          end
        end
      end else begin
        case (ADDR_I)
          `QHP_OFS_INT_ENABLE: next_rd_data[15:0] = interrupt_enable;
          `QHP_OFS_INT_STATUS: next_rd_data[15:0] = int_status;
          `QHP_OFS_RX_POINTER: next_rd_data[15:0] =
            {1'b0, rx_pointer_auto_step, 3'b000, rx_pointer_index}; // RULE17
          `QHP_OFS_RX_COMMAND: next_rd_data[15:0] = {15'h0000, rel_pending};
          default:             next_rd_data = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RD_DATA_O <= 32'h0000_0000;
    end else begin
      RD_DATA_O <= next_rd_data;
    end
  end

  // -------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------
  property p_auto_step;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (win_rd && rx_pointer_auto_step && !(rel_pending && RELEASE_DONE_I))
      |=> rx_pointer_index == 11'($past(rx_pointer_index) + $past(step));
  endproperty
  a_auto_step: assert property (p_auto_step) // RULE1
    else $error("pointer did not advance by the access width");

  property p_step_dword;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (win_rd && rx_pointer_auto_step && SIZE_I == qhp_pkg::QHP_DWORD
       && !rel_pending)
      |=> (rx_pointer_index - $past(rx_pointer_index)) == 11'h004;
  endproperty
  a_step_dword: assert property (p_step_dword) // RULE2
    else $error("dword read did not step the pointer by four");

  property p_no_auto;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (!rx_pointer_auto_step && !wr_ptr && !(rel_pending && RELEASE_DONE_I))
      |=> $stable(rx_pointer_index);
  endproperty
  a_no_auto: assert property (p_no_auto) // RULE3
    else $error("pointer moved with auto step clear");

  property p_reload;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (rel_pending && RELEASE_DONE_I)
      |=> rx_pointer_index == $past(RELEASE_PTR_I) && !RELEASE_REQ_O;
  endproperty
  a_reload: assert property (p_reload) // RULE4
    else $error("pointer not reloaded at release");

  property p_release_hold;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (wr_cmd && WR_DATA_I[0] && !rel_pending) ##1 !RELEASE_DONE_I
      |=> RELEASE_REQ_O;
  endproperty
  a_release_hold: assert property (p_release_hold) // RULE14
    else $error("release bit cleared before completion");

  property p_irq_raise;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (|(evt & interrupt_enable) && !wr_ien) |=> IRQ_O;
  endproperty
  a_irq_raise: assert property (p_irq_raise) // RULE15
    else $error("enabled event did not raise the interrupt");

  property p_irq_block;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (interrupt_enable == 16'h0000) |-> !IRQ_O;
  endproperty
  a_irq_block: assert property (p_irq_block) // RULE13
    else $error("interrupt raised with all enables clear");

  property p_sticky;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (int_status[15] && !(wr_ist && WR_DATA_I[15])) |=> int_status[15];
  endproperty
  a_sticky: assert property (p_sticky) // RULE16
    else $error("status bit lost without a write of one");

  property p_ptr_reserved;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (RD_I && ADDR_I == `QHP_OFS_RX_POINTER)
      |=> RD_DATA_O[31:15] == 17'h0_0000 && RD_DATA_O[13:11] == 3'b000;
  endproperty
  a_ptr_reserved: assert property (p_ptr_reserved) // RULE17
    else $error("reserved pointer bits read nonzero");

  // read data must fall back to zero so a stale word is never mistaken
  property p_rd_idle;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      !RD_I |=> RD_DATA_O == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) // RULE5
    else $error("read data stood beyond its cycle");

  property p_ien_reserved;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      wr_ien |=> interrupt_enable[6:0] == 7'h00;
  endproperty
  a_ien_reserved: assert property (p_ien_reserved) // RULE17
    else $error("reserved enable bits took a write");

  property p_status_set;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      evt[13] |=> int_status[13];
  endproperty
  a_status_set: assert property (p_status_set) // RULE16
    else $error("receive frame event did not latch its status bit");

  // window writes go to the transmit side and must not step the rx pointer
  property p_win_wr_ptr;
    @(posedge REF_CLK_I) disable iff (!RSTN_I)
      (win_wr && !(rel_pending && RELEASE_DONE_I)) |=> $stable(rx_pointer_index);
  endproperty
  a_win_wr_ptr: assert property (p_win_wr_ptr) // RULE1
    else $error("window write moved the receive pointer");

  c_auto_read: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    win_rd && rx_pointer_auto_step ##1 win_rd);
  c_release: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    rel_pending && RELEASE_DONE_I);
  c_irq: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    $rose(IRQ_O));
  c_wrap: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    win_rd && rx_pointer_auto_step && rx_pointer_index == 11'h7FF);
  c_slow_release: cover property (@(posedge REF_CLK_I) disable iff (!RSTN_I)
    rel_pending ##1 rel_pending ##1 rel_pending ##1 RELEASE_DONE_I);

endmodule : qhp_top

// [tb/qhp_qmgr_model.sv]
/*
  qhp_qmgr_model - behavioural queue manager facing the host data port:
  fills the receive queue once with a known byte pattern after reset and
  answers frame release requests after a chosen delay.
  Assumes: one clock shared with the port, reset active low.
*/
`timescale 1ns/1ps
module qhp_qmgr_model (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // receive queue fill
  output logic             rxq_wr_o,
  output logic [10:0]      rxq_addr_o,
  output logic [7:0]       rxq_data_o,
  output logic             fill_done_o,
  // release handshake
  input  wire logic        release_req_i,
  output logic             release_done_o,
  output logic [10:0]      release_ptr_o,
  input  wire logic [10:0] next_ptr_i,
  input  wire logic [3:0]  delay_i
);
  logic [11:0] fill_cnt;
  logic [3:0]  wait_cnt;
  logic [10:0] ptr;

  // one byte per cycle; data line follows the count so it changes on every fill cycle
  assign rxq_wr_o    = rstn_i & ~fill_cnt[11];
  assign rxq_addr_o  = fill_cnt[10:0];
  assign rxq_data_o  = fill_cnt[7:0] ^ 8'h5a ^ {5'h00, fill_cnt[10:8]};
  assign fill_done_o = fill_cnt[11];
  // pointer is only meaningful beside the done pulse, so show junk otherwise
  assign release_ptr_o = release_done_o ? ptr : ~ptr;

  // fill counter stops after the last queue byte
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fill_cnt <= 12'h000;
    end else if (!fill_cnt[11]) begin
      fill_cnt <= fill_cnt + 12'h001;
    end
  end

  // free the frame after delay_i cycles of pending request, one pulse only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      release_done_o <= 1'b0;
      wait_cnt       <= 4'h0;
      ptr            <= 11'h000;
    end else if (release_done_o) begin
      release_done_o <= 1'b0;
      wait_cnt       <= 4'h0;
    end else if (release_req_i) begin
      if (wait_cnt == delay_i) begin
        release_done_o <= 1'b1;
        ptr            <= next_ptr_i;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : qhp_qmgr_model

// [tb/tb_qhp_top.sv]
/*
  tb_qhp_top - self-checking bench for the queue host data port.
  Assumes: qhp_pkg and qhp_top compiled first; queue manager model beside.
*/
`timescale 1ns/1ps
module tb_qhp_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic               ref_clk = 1'b0;
  logic               rstn = 1'b0;
  logic [7:0]         addr = 8'h00;
  logic [31:0]        wdata = 32'h0000_0000;
  qhp_pkg::qhp_size_e size = qhp_pkg::QHP_BYTE;
  logic               wr = 1'b0;
  logic               rd = 1'b0;
  logic [31:0]        rdata;
  logic               rxq_wr;
  logic [10:0]        rxq_addr;
  logic [7:0]         rxq_data;
  logic [10:0]        tx_ptr = 11'h000;
  logic [10:0]        txq_addr = 11'h000;
  logic [7:0]         txq_data;
  logic               rel_req;
  logic               rel_done;
  logic [10:0]        rel_ptr;
  logic               fill_done;
  logic [10:0]        next_ptr = 11'h000;
  logic [3:0]         delay = 4'h0;
  qhp_pkg::qhp_irq_s  evt = '0;
  logic               irq;
  integer             n_mismatch = 0;
  integer             checks = 0;
  integer             seed = 32'h3c15;
  qhp_pkg::qhp_size_e sz [3] = '{qhp_pkg::QHP_BYTE, qhp_pkg::QHP_WORD,
                                 qhp_pkg::QHP_DWORD};

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  qhp_top uut (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .ADDR_I(addr),
    .WR_DATA_I(wdata), .SIZE_I(size), .WR_I(wr), .RD_I(rd),
    .RD_DATA_O(rdata), .RXQ_WR_I(rxq_wr), .RXQ_WR_ADDR_I(rxq_addr),
    .RXQ_WR_DATA_I(rxq_data), .TX_PTR_I(tx_ptr), .TXQ_RD_ADDR_I(txq_addr),
    .TXQ_RD_DATA_O(txq_data), .RELEASE_REQ_O(rel_req),
    .RELEASE_DONE_I(rel_done), .RELEASE_PTR_I(rel_ptr),
    .IRQ_EVT_I(evt), .IRQ_O(irq));

  qhp_qmgr_model qmgr (.clk_i(ref_clk), .rstn_i(rstn), .rxq_wr_o(rxq_wr),
    .rxq_addr_o(rxq_addr), .rxq_data_o(rxq_data), .fill_done_o(fill_done),
    .release_req_i(rel_req), .release_done_o(rel_done),
    .release_ptr_o(rel_ptr), .next_ptr_i(next_ptr), .delay_i(delay));

  // ---------------------------------------------------------------
  // expectations, comparison and bus cycles
  // ---------------------------------------------------------------
  function automatic logic [7:0] rxb(input logic [10:0] a);
    return a[7:0] ^ 8'h5a ^ {5'h00, a[10:8]};
  endfunction : rxb

  // n receive bytes from index p upward, wrapping in eleven bits
  function automatic logic [31:0] win(input logic [10:0] p, input int n);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int k = 0; k < n; k++) v[8*k +: 8] = rxb(p + 11'(k));
    return v;
  endfunction : win

  task automatic final_report;
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                        input qhp_pkg::qhp_size_e s);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    size  <= s;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input qhp_pkg::qhp_size_e s,
                        output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    size <= s;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input qhp_pkg::qhp_size_e s,
                        input logic [31:0] e, input logic [31:0] m);
    logic [31:0] d;
    rd_reg(a, s, d);
    chk(d & m, e & m);
  endtask : rd_chk

  // one-cycle event pulse, interrupt looked at once status has landed
  task automatic ev(input logic [15:0] v, input logic e);
    @(posedge ref_clk);
    evt <= qhp_pkg::qhp_irq_s'(v);
    @(posedge ref_clk);
    evt <= '0;
    #1 chk({31'h0, irq}, {31'h0, e});
  endtask : ev

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    int          j, n, off, o;
    logic [10:0] ep;
    logic        ea;
    logic [31:0] d;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rd_chk(8'h00, sz[1], 32'h0, 32'hffff_ffff);
    rd_chk(8'h06, sz[1], 32'h0, 32'hffff_ffff);
    rd_chk(8'h1e, sz[2], 32'h0, 32'hffff_ffff);
    wr_reg(8'h00, 32'h0000_ffff, sz[1]);
    rd_chk(8'h00, sz[1], 32'h0000_ff80, 32'hffff_ffff);
    wr_reg(8'h06, 32'h0000_ffff, sz[1]);
    rd_chk(8'h06, sz[1], 32'h0000_47ff, 32'hffff_ffff);
    // each enable alone: a neighbour event stays masked
    for (int b = 7; b < 16; b++) begin
      o = (b == 15) ? 7 : b + 1;
      wr_reg(8'h00, 32'(1) << b, sz[1]);
      ev(16'(1) << o | 16'h007f, 1'b0);
      ev(16'(1) << b, 1'b1);
      rd_chk(8'h02, sz[1], (32'(1) << b) | (32'(1) << o), 32'hffff);
      wr_reg(8'h02, 32'(1) << o, sz[1]);
      rd_chk(8'h02, sz[1], 32'(1) << b, 32'hffff);
      wr_reg(8'h02, 32'(1) << b, sz[1]);
      #1 chk({31'h0, irq}, 32'h0);
    end
    wait (fill_done === 1'b1);
    // random window reads, first one straddles the wrap at 2047
    ep = 11'h7ff;
    ea = 1'b1;
    for (int i = 0; i < 80; i++) begin
      j = (i == 0) ? 2 : $unsigned($random(seed)) % 3;
      n = 1 << j;
      off = (j == 2) ? 0 : ($unsigned($random(seed)) % 4) & ~(n - 1);
      if (i % 4 == 0) begin
        if (i > 0) ep = 11'($random(seed));
        if (i > 0) ea = 1'($random(seed));
        wr_reg(8'h06, {17'h0, ea, 3'h0, ep}, sz[1]);
      end
      rd_chk(8'h08 + 8'(off), sz[j], win(ep + 11'(off), n),
             32'hffff_ffff >> (32 - 8 * n));
      if (ea) ep = ep + 11'(n);
      if (i % 4 == 3)
        rd_chk(8'h06, sz[1], {17'h0, ea, 3'h0, ep}, 32'hffff);
    end
    // window writes land in the transmit queue and leave the rx pointer
    wr_reg(8'h06, 32'h0000_4123, sz[1]);
    for (int i = 0; i < 12; i++) begin
      j = i % 3;
      n = 1 << j;
      off = (j < 2 && i[0]) ? 2 : 0;
      d = $random(seed);
      @(posedge ref_clk);
      tx_ptr <= 11'($random(seed));
      wr_reg(8'h08 + 8'(off), d, sz[j]);
      for (int k = 0; k < n; k++) begin
        @(posedge ref_clk);
        txq_addr <= tx_ptr + 11'(off + k);
        @(posedge ref_clk);
        #1 chk({24'h0, txq_data}, {24'h0, d[8*k +: 8]});
      end
    end
    rd_chk(8'h06, sz[1], 32'h0000_4123, 32'hffff);
    // frame release with a prompt and a slow queue manager
    for (int r = 0; r < 2; r++) begin
      @(posedge ref_clk);
      next_ptr <= 11'($random(seed));
      delay    <= r ? 4'h9 : 4'h0;
      wr_reg(8'h0c, 32'h0000_0001, sz[1]);
      #1 chk({31'h0, rel_req}, 32'h1);
      if (r) rd_chk(8'h0c, sz[1], 32'h1, 32'hffff);
      o = 0;
      do begin
        rd_reg(8'h0c, sz[1], d);
        o++;
      end while (d[0] !== 1'b0 && o < 40);
      chk(d, 32'h0);
      chk({31'h0, rel_req}, 32'h0);
      rd_chk(8'h06, sz[1], {17'h0, 1'b1, 3'h0, next_ptr}, 32'hffff);
    end
    final_report();
  end

  // hang guard, far beyond the expected few thousand cycles
  initial begin
    #5_000_000;
    n_mismatch = n_mismatch + 1;
    final_report();
  end
endmodule : tb_qhp_top
